// *** include/ext_mode_pkg.sv ***
// package: constants, command codes and carrier structs for the mode-set controller
`default_nettype none
package ext_mode_pkg;
  // command pin pattern {cs_b, ras_b, cas_b, we_b}
  localparam logic [3:0] CMD_MODE_SET   = 4'h0;
  localparam logic [3:0] CMD_NOP        = 4'h7;
  localparam logic [3:0] CMD_DESELECT   = 4'hf;
  localparam logic [3:0] CMD_WRITE      = 4'h4;
  // bank address selects {ba2, ba1, ba0}
  localparam logic [2:0] BA_EXT_ONE     = 3'h1;
  localparam logic [2:0] BA_EXT_TWO     = 3'h2;
  localparam logic [2:0] BA_EXT_THREE   = 3'h3;
  // extended register two fields
  localparam int         EXT2_DCC_BIT   = 3;
  localparam int         EXT2_HTSR_BIT  = 7;
  // extended register one fields
  localparam int         EXT1_CAL_LSB   = 7;
  localparam int         EXT1_AL_LSB    = 3;
  localparam logic [12:0] EXT1_CAL_MASK = 13'h0380;
  localparam logic [2:0] CAL_EXIT       = 3'h0;
  localparam logic [2:0] CAL_DRIVE_HIGH = 3'h1;
  localparam logic [2:0] CAL_DRIVE_LOW  = 3'h2;
  localparam logic [2:0] CAL_ADJUST     = 3'h4;
  localparam logic [2:0] CAL_DEFAULT    = 3'h7;
  // timing, in ns, and clock period
  localparam int         CLK_PERIOD_NS  = 40;
  localparam int         MRD_NS         = 15;
  localparam int         AOFD_NS        = 20;
  localparam int         MOD_NS         = 12;
  localparam int         OIT_NS         = 12;
  localparam logic [7:0] MRD_CYC  = 8'((MRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] AOFD_CYC = 8'((AOFD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] MOD_CYC  = 8'((MOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] OIT_CYC  = 8'((OIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CYC_ONE  = 8'h01;
  localparam logic [1:0] BURST_LAST = 2'h3;
  // software port offsets (word addresses)
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_ADDR   = 4'h1;
  localparam logic [3:0] OFF_CODE   = 4'h2;
  localparam logic [3:0] OFF_LAT    = 4'h3;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  // control register command field values
  localparam logic [2:0] OP_EXT_TWO   = 3'h1;
  localparam logic [2:0] OP_EXT_THREE = 3'h2;
  localparam logic [2:0] OP_EXT_ONE   = 3'h3;
  localparam logic [2:0] OP_ADJUST    = 3'h4;
  localparam int         CTRL_BANKS_IDLE_BIT = 3;
  localparam int         CTRL_TERM_BIT       = 4;
  // memory command pins travel together
  typedef struct packed {
    logic        cs_b;
    logic        ras_b;
    logic        cas_b;
    logic        we_b;
    logic [2:0]  ba;
    logic [12:0] addr;
  } mem_cmd_type;
  // controller states
  typedef enum logic [2:0] {
    ST_IDLE, ST_TERM_OFF, ST_ISSUE, ST_WAIT_WL, ST_BURST, ST_EXIT, ST_SETTLE
  } seq_state_type;
endpackage : ext_mode_pkg
`default_nettype wire

// *** src/ext_mode_ctrl.sv ***
// host controller that programs extended mode registers and runs driver calibration
// What this block does
// - extended two write uses ba1 high, others low
// - issue only with banks idle, cke high
// - wait mode-set delay after every mode write
// - rewrite allowed only while all banks idle
// - reserved extended-two bits forced to zero
// - lowest three bits zero without partial refresh
// - extended three written all zeros
// - every calibration command followed by exit
// - adjust code on all data lines, fixed order
// - adjust command keeps additive latency
// - plain writes carry zero calibration field
// - code sent at read latency minus one
// - termination off before and during update
//
// Strobed register access and the address map were chosen for this implementation.
`default_nettype none
module ext_mode_ctrl
(
  input  wire logic                      clk_i,         // 25 MHz command clock
  input  wire logic                      rst_b_i,       // async reset, active low
  input  wire logic                      clk_en_i,      // freezes all state when low
  input  wire logic [3:0]                addr_i,        // software word address
  input  wire logic [15:0]               wdata_i,       // software write data
  input  wire logic                      wr_i,          // write strobe
  input  wire logic                      rd_i,          // read strobe
  output logic      [15:0]               rdata_o,       // read data, cycle after rd_i
  output ext_mode_pkg::mem_cmd_type      cmd_o,         // memory command pins
  output logic                           cke_o,         // memory clock enable
  output logic                           term_ctrl_o,   // termination control pin
  output logic      [15:0]               dq_o,          // data out
  output logic                           dq_oe_o,       // data output enable
  output logic                           dqs_o,         // true strobe out
  output logic                           dqs_b_o,       // complement strobe out
  output logic                           dqs_oe_o,      // strobe output enable
  output logic                           busy_o         // sequence in progress
);

  // all state in one packed struct
  typedef struct packed {
    ext_mode_pkg::seq_state_type st;        // sequencer state
    ext_mode_pkg::mem_cmd_type   cmd;       // command pins
    logic                        cke;       // clock enable to memory
    logic                        term;      // termination pin as software wants it
    logic                        term_pin;  // termination pin as driven
    logic [15:0]                 dq;        // data lines
    logic                        dq_oe;     // data drive
    logic                        dqs;       // strobe
    logic                        dqs_oe;    // strobe drive
    logic                        dqs_b;     // complement strobe, own flop so the pin has no gate
    logic [15:0]                 rdata;     // read data register
    logic [2:0]                  op;        // pending operation
    logic                        banks_idle;// software says all banks precharged
    logic [12:0]                 arg;       // address argument
    logic [3:0]                  code;      // adjust code nibble
    logic [2:0]                  al;        // additive latency shadow
    logic [2:0]                  cl;        // column latency shadow
    logic [7:0]                  cnt;       // delay counter
    logic [1:0]                  beat;      // burst bit time
    logic                        done;      // sticky completion flag
    logic                        busy;      // sequence running, registered for a clean pin
  } state_type;

  state_type s_r;   // registered state
  state_type s_nxt; // next state

  // next-state logic: software port plus command sequencer
  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.cmd = '{cs_b: 1'b1, ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, ba: 3'h0, addr: 13'h0};
    s_nxt.rdata = 16'h0;
    // read data stands only in the cycle after the strobe
    // unselected cycles return zero so a wired-or bus needs no mux
    if (rd_i)
    begin
      case (addr_i)
        ext_mode_pkg::OFF_ADDR:   s_nxt.rdata = {3'h0, s_r.arg};
        ext_mode_pkg::OFF_CODE:   s_nxt.rdata = {12'h0, s_r.code};
        ext_mode_pkg::OFF_LAT:    s_nxt.rdata = {10'h0, s_r.cl, s_r.al};
        ext_mode_pkg::OFF_STATUS: s_nxt.rdata = {11'h0, s_r.done, s_r.banks_idle,
                                                 s_r.st != ext_mode_pkg::ST_IDLE, s_r.op[1:0]};
        default:                  s_nxt.rdata = 16'h0; // unmapped reads zero
      endcase
    end
    // writes; a control write starts an op only while idle
    if (wr_i)
    begin
      case (addr_i)
        ext_mode_pkg::OFF_ADDR: s_nxt.arg  = wdata_i[12:0];
        ext_mode_pkg::OFF_CODE: s_nxt.code = wdata_i[3:0];
        ext_mode_pkg::OFF_LAT:
        begin
          s_nxt.al = wdata_i[2:0];
          s_nxt.cl = wdata_i[5:3];
        end
        ext_mode_pkg::OFF_CTRL:
        begin
          s_nxt.banks_idle = wdata_i[ext_mode_pkg::CTRL_BANKS_IDLE_BIT];
          s_nxt.term       = wdata_i[ext_mode_pkg::CTRL_TERM_BIT];
          // only start with banks idle
          if (s_r.st == ext_mode_pkg::ST_IDLE && wdata_i[2:0] != 3'h0
              && wdata_i[ext_mode_pkg::CTRL_BANKS_IDLE_BIT])
          begin
            s_nxt.op   = wdata_i[2:0];
            s_nxt.done = 1'b0;
            s_nxt.st   = ext_mode_pkg::ST_TERM_OFF;
            s_nxt.cnt  = ext_mode_pkg::AOFD_CYC;
          end
        end
        default: ;
      endcase
    end
    // termination follows software except around mode writes
    s_nxt.term_pin = (s_nxt.st == ext_mode_pkg::ST_IDLE) ? s_nxt.term : 1'b0;
    case (s_r.st)
      // idle: pins deselected, termination follows software
      ext_mode_pkg::ST_IDLE: ;
      // termination-off delay before the mode write
      // the pin already drops on the edge that accepts the order,
      // so this state only adds margin on top of the delay
      ext_mode_pkg::ST_TERM_OFF:
      begin
        s_nxt.term_pin = 1'b0;
        if (s_r.cnt > ext_mode_pkg::CYC_ONE)
          s_nxt.cnt = s_r.cnt - ext_mode_pkg::CYC_ONE;
        else
          s_nxt.st = ext_mode_pkg::ST_ISSUE;
      end
      // one mode-set command
      // the pins stand for a single cycle; the default at the top returns them
      // to deselect on the next edge without any extra state
      ext_mode_pkg::ST_ISSUE:
      begin
        s_nxt.cmd.cs_b  = 1'b0;
        s_nxt.cmd.ras_b = 1'b0;
        s_nxt.cmd.cas_b = 1'b0;
        s_nxt.cmd.we_b  = 1'b0;
        // settle covers both the mode-set delay and the update window
        s_nxt.cnt       = (ext_mode_pkg::MOD_CYC > ext_mode_pkg::MRD_CYC)
                          ? ext_mode_pkg::MOD_CYC : ext_mode_pkg::MRD_CYC;
        s_nxt.st        = ext_mode_pkg::ST_SETTLE;
        case (s_r.op)
          ext_mode_pkg::OP_EXT_TWO:
          begin
            s_nxt.cmd.ba = ext_mode_pkg::BA_EXT_TWO;
            // only duty corrector and hot refresh pass
            s_nxt.cmd.addr = 13'h0;
            s_nxt.cmd.addr[ext_mode_pkg::EXT2_DCC_BIT]  = s_r.arg[ext_mode_pkg::EXT2_DCC_BIT];
            s_nxt.cmd.addr[ext_mode_pkg::EXT2_HTSR_BIT] = s_r.arg[ext_mode_pkg::EXT2_HTSR_BIT];
          end
          ext_mode_pkg::OP_EXT_THREE:
          begin
            s_nxt.cmd.ba   = ext_mode_pkg::BA_EXT_THREE;
            s_nxt.cmd.addr = 13'h0;
          end
          ext_mode_pkg::OP_EXT_ONE:
          begin
            s_nxt.cmd.ba   = ext_mode_pkg::BA_EXT_ONE;
            s_nxt.cmd.addr = s_r.arg;
            // drive-mode and default codes stay, anything else clears the field
            if (s_r.arg[9:7] != ext_mode_pkg::CAL_DRIVE_HIGH
                && s_r.arg[9:7] != ext_mode_pkg::CAL_DRIVE_LOW
                && s_r.arg[9:7] != ext_mode_pkg::CAL_DEFAULT)
              s_nxt.cmd.addr = s_r.arg & ~ext_mode_pkg::EXT1_CAL_MASK;
            // drive modes and default still need an exit
            if (s_r.arg[9:7] != ext_mode_pkg::CAL_EXIT
                && s_nxt.cmd.addr[9:7] != ext_mode_pkg::CAL_EXIT)
            begin
              s_nxt.st  = ext_mode_pkg::ST_EXIT;
              s_nxt.cnt = (ext_mode_pkg::OIT_CYC > ext_mode_pkg::MRD_CYC)
                          ? ext_mode_pkg::OIT_CYC : ext_mode_pkg::MRD_CYC;
            end
          end
          default:
          begin
            // adjust mode, keep latency field
            s_nxt.cmd.ba   = ext_mode_pkg::BA_EXT_ONE;
            s_nxt.cmd.addr = s_r.arg & ~ext_mode_pkg::EXT1_CAL_MASK;
            s_nxt.cmd.addr[ext_mode_pkg::EXT1_CAL_LSB +: 3] = ext_mode_pkg::CAL_ADJUST;
            s_nxt.cmd.addr[ext_mode_pkg::EXT1_AL_LSB +: 3]  = s_r.al;
            // write latency is al plus cl minus one
            s_nxt.cnt = 8'({5'h0, s_r.al} + {5'h0, s_r.cl});
            s_nxt.st  = ext_mode_pkg::ST_WAIT_WL;
          end
        endcase
      end
      // count down to the write latency edge; preamble in the last cycle
      // a latency sum below two leaves no room for the preamble; software must avoid it
      ext_mode_pkg::ST_WAIT_WL:
      begin
        if (s_r.cnt > ext_mode_pkg::CYC_ONE + ext_mode_pkg::CYC_ONE)
          s_nxt.cnt = s_r.cnt - ext_mode_pkg::CYC_ONE;
        else
        begin
          s_nxt.dqs_oe = 1'b1;
          s_nxt.dqs    = 1'b0;
          s_nxt.st     = ext_mode_pkg::ST_BURST;
          s_nxt.beat   = 2'h0;
        end
      end
      // four bit times of the code on every data line
      // the strobe toggles once per beat, so its first rise lands with bit time 0
      ext_mode_pkg::ST_BURST:
      begin
        s_nxt.dq_oe = 1'b1;
        s_nxt.dqs   = ~s_r.dqs;
        s_nxt.dq    = {16{s_r.code[2'h3 - s_r.beat]}}; // bit time 0 first
        s_nxt.beat  = s_r.beat + 2'h1;
        if (s_r.beat == ext_mode_pkg::BURST_LAST)
        begin
          s_nxt.st  = ext_mode_pkg::ST_EXIT;
          s_nxt.cnt = ext_mode_pkg::MRD_CYC;
        end
      end
      // calibration exit after the wait
      ext_mode_pkg::ST_EXIT:
      begin
        s_nxt.dq_oe  = 1'b0;
        s_nxt.dqs_oe = 1'b0;
        // count to zero so a deselect cycle always separates
        // the calibration command from its exit
        if (s_r.cnt > 8'h00)
          s_nxt.cnt = s_r.cnt - ext_mode_pkg::CYC_ONE;
        else
        begin
          s_nxt.cmd = '{cs_b: 1'b0, ras_b: 1'b0, cas_b: 1'b0, we_b: 1'b0,
                        ba: ext_mode_pkg::BA_EXT_ONE,
                        addr: (s_r.arg & ~ext_mode_pkg::EXT1_CAL_MASK)};
          s_nxt.cmd.addr[ext_mode_pkg::EXT1_AL_LSB +: 3] = s_r.al;
          s_nxt.cnt = (ext_mode_pkg::OIT_CYC > ext_mode_pkg::MRD_CYC)
                      ? ext_mode_pkg::OIT_CYC : ext_mode_pkg::MRD_CYC;
          s_nxt.st  = ext_mode_pkg::ST_SETTLE;
          s_nxt.op  = ext_mode_pkg::OP_EXT_ONE;
        end
      end
      // mode-set delay and update window with termination low
      ext_mode_pkg::ST_SETTLE:
      begin
        s_nxt.term_pin = 1'b0;
        // count to zero: the pin stays low through the whole update window
        // and no new order can start before the mode-set delay has passed
        if (s_r.cnt > 8'h00)
          s_nxt.cnt = s_r.cnt - ext_mode_pkg::CYC_ONE;
        else
        begin
          s_nxt.st   = ext_mode_pkg::ST_IDLE;
          s_nxt.done = 1'b1;
          s_nxt.term_pin = s_nxt.term;
        end
      end
      default: s_nxt.st = ext_mode_pkg::ST_IDLE;
    endcase
    s_nxt.cke = 1'b1; // held high once out of reset
    // both registered here so every pin leaves a flop directly
    s_nxt.dqs_b = ~s_nxt.dqs;
    s_nxt.busy  = (s_nxt.st != ext_mode_pkg::ST_IDLE);
  end

  // state register with clock enable
  // a low enable holds every field, counters included, so a paused sequence
  // resumes exactly where it stopped
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_r       <= '0;
      s_r.st    <= ext_mode_pkg::ST_IDLE;
      s_r.cmd   <= '{cs_b: 1'b1, ras_b: 1'b1, cas_b: 1'b1, we_b: 1'b1, ba: 3'h0, addr: 13'h0};
      s_r.dqs_b <= 1'b1; // complement strobe idles high
    end
    else if (clk_en_i)
      s_r <= s_nxt;
  end

  // outputs straight from state flops
  // no gate sits between a flop and a pin, so pins never glitch
  assign rdata_o     = s_r.rdata;
  assign cmd_o       = s_r.cmd;
  assign cke_o       = s_r.cke;
  assign term_ctrl_o = s_r.term_pin;
  assign dq_o        = s_r.dq;
  assign dq_oe_o     = s_r.dq_oe;
  assign dqs_o       = s_r.dqs;
  assign dqs_b_o     = s_r.dqs_b;
  assign dqs_oe_o    = s_r.dqs_oe;
  assign busy_o      = s_r.busy;

endmodule : ext_mode_ctrl
`default_nettype wire

// *** tb/ext_mode_ctrl_chk.sv ***
// checker: command-pin and calibration-burst properties of the controller
`default_nettype none
module ext_mode_ctrl_chk
(
  input wire logic                      clk_i,       // command clock
  input wire logic                      rst_b_i,     // async reset, active low
  input wire ext_mode_pkg::mem_cmd_type cmd_o,       // memory command pins
  input wire logic                      cke_o,       // memory clock enable
  input wire logic                      term_ctrl_o, // termination pin
  input wire logic [15:0]               dq_o,        // data out
  input wire logic                      dq_oe_o,     // data output enable
  input wire logic                      dqs_o,       // true strobe
  input wire logic                      dqs_b_o,     // complement strobe
  input wire logic                      dqs_oe_o     // strobe output enable
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic mset;   // any mode-set command on the pins
  logic cal_c;  // extended one write that enters a calibration mode
  logic exit_c; // extended one write with calibration field cleared
  assign mset = {cmd_o.cs_b, cmd_o.ras_b, cmd_o.cas_b, cmd_o.we_b} == ext_mode_pkg::CMD_MODE_SET;
  assign cal_c = mset && cmd_o.ba == ext_mode_pkg::BA_EXT_ONE && cmd_o.addr[9:7] != 3'h0;
  assign exit_c = mset && cmd_o.ba == ext_mode_pkg::BA_EXT_ONE && cmd_o.addr[9:7] == 3'h0;
  // four beats exactly, then the bus is released
  sequence s_burst;
    dq_oe_o [*4] ##1 !dq_oe_o;
  endsequence
  // strobe low one cycle with data still off, then first beat on a rising strobe
  sequence s_preamble;
    (dqs_oe_o && !dqs_o && !dq_oe_o) ##1 (dq_oe_o && dqs_o);
  endsequence
  sequence s_ext2;
    mset && cmd_o.ba == ext_mode_pkg::BA_EXT_TWO;
  endsequence
  chk_term_before: assert property (mset |-> !term_ctrl_o && !$past(term_ctrl_o))
    else $error("termination high at or just before mode command");
  chk_term_window: assert property (mset |=> !term_ctrl_o)
    else $error("termination high inside update window");
  chk_mset_gap: assert property (mset |=> cmd_o.cs_b)
    else $error("command issued inside mode-set delay");
  chk_cke_high: assert property (mset |-> cke_o && $past(cke_o))
    else $error("mode command without clock enable settled high");
  chk_ext2_resvd: assert property (s_ext2 |-> (cmd_o.addr & 13'h1f77) == 13'h0000)
    else $error("reserved extended two bits not zero");
  chk_ext3_zero: assert property (mset && cmd_o.ba == ext_mode_pkg::BA_EXT_THREE
                                  |-> cmd_o.addr == 13'h0000)
    else $error("extended three written nonzero");
  chk_cal_exit: assert property (cal_c |-> ##[2:40] exit_c)
    else $error("calibration command not followed by exit");
  chk_cal_quiet: assert property (cal_c |=> (!mset until exit_c))
    else $error("other mode command before calibration exit");
  chk_burst_len: assert property ($rose(dq_oe_o) |-> s_burst)
    else $error("adjust burst not four beats");
  chk_burst_same: assert property (dq_oe_o |-> dq_o == {16{dq_o[0]}})
    else $error("adjust code differs between data lines");
  chk_strobe_preamble: assert property ($rose(dqs_oe_o) |-> s_preamble)
    else $error("strobe preamble missing before adjust burst");
  chk_strobe_pair: assert property (dqs_oe_o |-> dqs_b_o != dqs_o)
    else $error("complement strobe not inverse of true strobe");
endmodule : ext_mode_ctrl_chk
bind ext_mode_ctrl ext_mode_ctrl_chk ext_mode_ctrl_chk_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .cmd_o(cmd_o), .cke_o(cke_o), .term_ctrl_o(term_ctrl_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
  .dqs_o(dqs_o), .dqs_b_o(dqs_b_o), .dqs_oe_o(dqs_oe_o));
`default_nettype wire

// *** tb/ddr2_dev_model.sv ***
// device model: mode-set decode, adjust burst capture, driver strength steps
`default_nettype none
module ddr2_dev_model
(
  input  wire logic                      clk_i,   // command clock
  input  wire logic                      rst_b_i, // async reset, active low
  input  wire logic                      cke_i,   // commands ignored while low
  input  wire ext_mode_pkg::mem_cmd_type cmd_i,   // command pins
  input  wire logic [15:0]               dq_i,    // data lines
  input  wire logic                      dq_oe_i, // controller drives data
  output logic      [12:0]               ext1_o,  // last extended one value
  output logic      [12:0]               ext2_o,  // extended two contents
  output logic      [12:0]               ext3_o,  // extended three contents
  output logic      [2:0]                al_o,    // latency seen with adjust
  output logic      [3:0]                pu_o,    // common pull-up step
  output logic      [3:0]                pd_o,    // common pull-down step
  output logic      [7:0]                wl_o,    // cycles command to first beat
  output logic                           drv_o,   // device drivers on in a drive mode
  output logic      [3:0]                drv_cnt_o // drive modes entered
);
  logic [3:0] code_r; // first bit time ends in bit 3
  logic [1:0] beat_r; // beat index in the burst
  logic [7:0] cnt_r;  // cycles since adjust command
  logic [3:0] c;      // code including this beat
  logic       mset;   // mode-set seen this edge
  logic       drv_c;  // extended one value selects a drive mode
  assign drv_c = cmd_i.addr[9:7] == ext_mode_pkg::CAL_DRIVE_HIGH
                 || cmd_i.addr[9:7] == ext_mode_pkg::CAL_DRIVE_LOW;
  assign c = {code_r[2:0], dq_i[0]};
  assign mset = cke_i && {cmd_i.cs_b, cmd_i.ras_b, cmd_i.cas_b, cmd_i.we_b} == 4'h0;
  // one step, held at the ends of the sixteen-step range
  function automatic logic [3:0] step(input logic [3:0] s, input logic up, input logic dn);
    step = (up && !dn && s != 4'hf) ? s + 4'h1 : (dn && !up && s != 4'h0) ? s - 4'h1 : s;
  endfunction : step
  // register capture and calibration; defaults odd on purpose to expose missed writes
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      {ext1_o, ext2_o, ext3_o} <= {3{13'h1fff}};
      {al_o, code_r, beat_r, cnt_r, wl_o} <= '0;
      {pu_o, pd_o} <= 8'h88; // start mid-range
      {drv_o, drv_cnt_o} <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + 8'h01;
      if (mset)
      begin
        case (cmd_i.ba)
          ext_mode_pkg::BA_EXT_ONE:
          begin
            ext1_o <= cmd_i.addr;
            // drivers follow the last extended one write; the exit turns them off
            drv_o <= drv_c;
            drv_cnt_o <= drv_cnt_o + {3'h0, drv_c};
            if (cmd_i.addr[9:7] == ext_mode_pkg::CAL_ADJUST)
            begin
              al_o <= cmd_i.addr[5:3];
              cnt_r <= 8'h00;
            end
          end
          ext_mode_pkg::BA_EXT_TWO: ext2_o <= cmd_i.addr;
          ext_mode_pkg::BA_EXT_THREE: ext3_o <= cmd_i.addr;
          default: ;
        endcase
      end
      if (dq_oe_i)
      begin
        code_r <= c;
        beat_r <= beat_r + 2'h1;
        if (beat_r == 2'h0)
          wl_o <= cnt_r;
        // reserved codes change nothing; one setting for all lines
        if (beat_r == 2'h3 && !(c[0] && c[1]) && !(c[2] && c[3]))
        begin
          pu_o <= step(pu_o, c[0], c[1]);
          pd_o <= step(pd_o, c[2], c[3]);
        end
      end
    end
  end
endmodule : ddr2_dev_model
`default_nettype wire

// *** tb/test_ext_mode_ctrl.sv ***
// self-checking bench for the mode-set and calibration controller
`default_nettype none
module test_ext_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, clk_en_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, dq_o;
  ext_mode_pkg::mem_cmd_type cmd_o;
  logic cke_o, term_ctrl_o, dq_oe_o, dqs_o, dqs_b_o, dqs_oe_o, busy_o;
  logic [12:0] ext1, ext2, ext3;
  logic [2:0] al;
  logic [3:0] pu, pd;
  logic [7:0] wl;
  logic drv;
  logic [3:0] drv_cnt;
  int num_errors = 0, check_count = 0;
  always #20 clk_i = ~clk_i;
  ext_mode_ctrl ext_mode_ctrl_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cmd_o(cmd_o), .cke_o(cke_o), .term_ctrl_o(term_ctrl_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .dqs_o(dqs_o), .dqs_b_o(dqs_b_o), .dqs_oe_o(dqs_oe_o), .busy_o(busy_o));
  ddr2_dev_model ddr2_dev_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .cke_i(cke_o),
    .cmd_i(cmd_o), .dq_i(dq_o), .dq_oe_i(dq_oe_o), .ext1_o(ext1), .ext2_o(ext2),
    .ext3_o(ext3), .al_o(al), .pu_o(pu), .pd_o(pd), .wl_o(wl), .drv_o(drv),
    .drv_cnt_o(drv_cnt));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one write cycle, strobe dropped at the edge that takes it
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // one read cycle; data taken in the single cycle it stands
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk({16'h0000, rdata_o}, exp);
  endtask : rd
  task go(input logic [15:0] c); // start an op, wait bounded for it to end
    int n;
    wr(ext_mode_pkg::OFF_CTRL, c);
    #1 chk({31'h0, busy_o}, 32'h1);
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1 n++;
    end while (busy_o !== 1'b0 && n < 200);
  endtask : go
  task adj(input logic [3:0] code, input logic [3:0] ep, input logic [3:0] ed);
    wr(ext_mode_pkg::OFF_CODE, {12'h000, code});
    go(16'h001c);
    chk({8'h00, pu, pd}, {8'h00, ep, ed});
    chk({8'h00, wl}, 16'h0004);
    chk({13'h0000, al}, 16'h0002);
  endtask : adj
  task results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    results();
  end
  initial
  begin
    #30 chk({cmd_o, cke_o, 2'h0}, {4'hf, 3'h0, 13'h0, 3'h0}); // idle pins in reset
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(4'hf, 32'h0); // unmapped word reads zero
    clk_en_i <= 1'b0;
    wr(ext_mode_pkg::OFF_CODE, 16'h0003); // frozen, must not land
    clk_en_i <= 1'b1;
    rd(ext_mode_pkg::OFF_CODE, 32'h0); // clock enable low holds state
    $display("test reset done");
    wr(ext_mode_pkg::OFF_ADDR, 16'h1fff);
    rd(ext_mode_pkg::OFF_ADDR, 32'h1fff);
    go(16'h0009);
    chk({3'h0, ext2}, 16'h0088);
    wr(ext_mode_pkg::OFF_CTRL, 16'h0002); // start with banks flagged busy
    wr(ext_mode_pkg::OFF_CTRL, 16'h0009);
    wr(ext_mode_pkg::OFF_CTRL, 16'h000a); // second op while busy
    repeat (20) @(posedge clk_i);
    chk({3'h0, ext3}, 16'h1fff);
    go(16'h000a);
    chk({3'h0, ext3}, 16'h0000);
    rd(ext_mode_pkg::OFF_STATUS, 32'h001a);
    $display("test ext two and three done");
    wr(ext_mode_pkg::OFF_CTRL, 16'h0010);
    repeat (3) @(posedge clk_i);
    chk({15'h0, term_ctrl_o}, 16'h0001);
    for (int i = 0; i < 3; i++)
    begin
      wr(ext_mode_pkg::OFF_ADDR, {6'h00, i == 0 ? 3'h1 : i == 1 ? 3'h2 : 3'h7, 7'h00});
      go(16'h001b);
      chk({13'h0, ext1[9:7]}, 16'h0000);
    end
    chk({27'h0, drv, drv_cnt}, 32'h0000_0002);
    $display("test drive modes done");
    wr(ext_mode_pkg::OFF_LAT, 16'h001a); // al 2, cl 3
    rd(ext_mode_pkg::OFF_LAT, 32'h001a);
    for (int i = 1; i <= 8; i++)
      adj(4'h5, (i < 8) ? 4'(8 + i) : 4'hf, (i < 8) ? 4'(8 + i) : 4'hf);
    chk({8'h00, pu, pd}, 16'h00ff);
    adj(4'hf, 4'hf, 4'hf);
    adj(4'h6, 4'he, 4'hf);
    adj(4'h9, 4'hf, 4'he);
    adj(4'ha, 4'he, 4'hd);
    adj(4'h0, 4'he, 4'hd);
    chk({15'h0, term_ctrl_o}, 16'h0001);
    $display("test adjust done");
    results();
  end
endmodule : test_ext_mode_ctrl
`default_nettype wire
